/* File: sdbs_bank.v */
// Purpose: one bank's row state and precharge timer
// Assumes: act and pre are one-cycle pulses, never together
// Notes: busy shows precharge still in progress
`timescale 1ns/10ps
module sdbs_bank #(
	parameter ROW_W = 16,
	parameter TRP_CYC = 1
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Commands
	input wire act,
	input wire pre,
	input wire [ROW_W-1:0] row,
	// State
	output reg is_open,
	output reg [ROW_W-1:0] open_row,
	output reg busy
);
	localparam CW = 8;
	reg [CW-1:0] trp_cnt;
	always @(posedge clk) begin
		if (rst) begin
			is_open <= 1'b0;
			open_row <= {ROW_W{1'b0}};
			busy <= 1'b0;
			trp_cnt <= {CW{1'b0}};
		end else begin
			// R6 row opens
			if (act) begin
				is_open <= 1'b1;
				open_row <= row;
			end
			// R7 R14 close, restart timer
			if (pre) begin
				is_open <= 1'b0;
				busy <= 1'b1;
				trp_cnt <= TRP_CYC[CW-1:0];
			end else if (busy) begin
				if (trp_cnt <= 8'h01)
					busy <= 1'b0;
				trp_cnt <= trp_cnt - 8'h01;
			end
		end
	end
endmodule // sdbs_bank

/* File: sdbs_ctl_model.sv */
// Purpose: controller model driving the command pins
// Assumes: one command per clock, NOP after it
// Notes: idle address pins invert so stale values never look valid
`timescale 1ns/10ps
module sdbs_ctl_model (
	// Clock
	input wire clk,
	// Command pins
	output reg cs_n,
	output reg ras_n,
	output reg cas_n,
	output reg we_n,
	output reg [2:0] ba,
	output reg [15:0] a
);
	initial begin
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		ba = 3'h0;
		a = 16'h0;
	end
	// caller orders ACT, PRE and READ
	task issue(input [2:0] k, input [2:0] b, input [15:0] x);
		begin
			@(posedge clk);
			cs_n <= 1'b0;
			{ras_n, cas_n, we_n} <= k;
			ba <= b;
			a <= x;
			@(posedge clk);
			cs_n <= 1'b1;
			{ras_n, cas_n, we_n} <= 3'h7;
			ba <= ~b;
			a <= ~x;
			// idle gap beyond row precharge time
			repeat (4) @(posedge clk);
		end
	endtask
endmodule // sdbs_ctl_model

/* File: sdbs_defs.vh */
// Purpose: constants for the SDRAM bank state and calibration readout block
// Assumes: 10 MHz system clock, command pins sampled once per clock
// Notes: byte addresses are word aligned on the Avalon-MM slave
//
// Overview of operation
// R1 - Calibration location with eight beats returns 0,1,0,1,0,1,0,1 in order.
// R2 - Chopped calibration readout returns 0,1,0,1 from positions 0-3 or 4-7.
// R3 - Low two bits of mode register three pick location; 01,10,11 reserved.
// R4 - Read address 2:0 of 000 starts at 0, 100 starts chopped at 4.
// R5 - Burst position 0 is location LSB, position 7 is location MSB.
// R6 - ACTIVE opens the row on A0-A15 in the bank on BA0-BA2.
// R7 - An activated row stays open until a PRECHARGE reaches its bank.
// R8 - Controller precharges a bank before activating a different row there.
// R9 - PRECHARGE closes one addressed bank or all banks, by command form.
// R10 - Controller waits row precharge time before activating a precharged bank.
// R11 - Concurrent auto precharge allows accesses to other banks within timing limits.
// R12 - A precharged bank is idle and needs ACTIVE before READ or WRITE.
// R13 - PRECHARGE to an idle or already precharging bank is accepted silently.
// R14 - Repeated PRECHARGE restarts precharge timing from the latest one.
// R15 - Mode register three bit 2 enables readout; zero returns to array.
// R16 - Lane 0 of each byte carries the bit; other lanes copy or zero.
// R17 - With on-the-fly chop, A12 low gives four beats, high eight.
// R18 - Controller locks the delay-locked loop before readout reads.
// R19 - Each of eight banks tracks idle or open with its open row.
// R20 - Reserved location reads give a defined value, touching no bank state.
`ifndef SDBS_DEFS_VH
`define SDBS_DEFS_VH
`define SDBS_CLK_PERIOD_NS 100
`define SDBS_TRP_NS 15
`define SDBS_TRP_CYC ((`SDBS_TRP_NS + `SDBS_CLK_PERIOD_NS - 1) / `SDBS_CLK_PERIOD_NS)
`define SDBS_READ_LAT 6
`define SDBS_ADDR_CTRL 4'h0
`define SDBS_ADDR_STATUS 4'h4
`define SDBS_ADDR_BANK_SEL 4'h8
`define SDBS_ADDR_BANK_ROW 4'hC
`define SDBS_CTRL_REPLICATE 0
`define SDBS_MODE_THREE_READOUT_EN 2
`define SDBS_BL_FIXED8 2'h0
`define SDBS_BL_OTF 2'h1
`define SDBS_BL_FIXED4 2'h2
`define SDBS_LOC_CALIB 2'h0
`define SDBS_CALIB_PATTERN 8'hAA
`define SDBS_RSVD_PATTERN 8'h00
`define SDBS_BA_MODE_ZERO 3'h0
`define SDBS_BA_MODE_THREE 3'h3
`define SDBS_CMD_MRS 3'h0
`define SDBS_CMD_PRE 3'h2
`define SDBS_CMD_ACT 3'h3
`define SDBS_CMD_READ 3'h5
`define SDBS_AP_BIT 10
`define SDBS_BC_BIT 12
`endif

/* File: sdbs_monitor.sv */
// Purpose: port checks on the readout lanes
// Assumes: location taken from raw command pins
// Notes: reads in array mode must stay silent
`timescale 1ns/10ps
module sdbs_monitor #(
	parameter ROW_W = 16,
	parameter READ_LAT = 6
) (
	// Clock and reset
	input wire CLK_SYS,
	input wire RST,
	// Command pins
	input wire CS_N,
	input wire RAS_N,
	input wire CAS_N,
	input wire WE_N,
	input wire [2:0] BA,
	input wire [ROW_W-1:0] A,
	// Data lanes
	input wire [15:0] DQ_OUT,
	input wire DQ_OE_N,
	input wire READOUT_VALID
);
	reg [1:0] loc;
	reg [4:0] since;
	reg ro_en;
	wire [3:0] k = {CS_N, RAS_N, CAS_N, WE_N};
	always @(posedge CLK_SYS) begin
		if (RST) begin
			loc <= 2'h0;
			since <= 5'h1F;
			ro_en <= 1'b0;
		end else begin
			if (k == 4'h0 && BA == 3'h3) begin
				loc <= A[1:0];
				ro_en <= A[2];
			end
			if (k == 4'h5)
				since <= 5'h0;
			else if (since != 5'h1F)
				since <= since + 5'h1;
		end
	end
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);
	drive_en_a: assert property (READOUT_VALID |-> !DQ_OE_N)
		else $error("lanes not driven");
	lane_copy_a: assert property (READOUT_VALID |-> DQ_OUT[8] == DQ_OUT[0] && !(DQ_OUT & ~{16{DQ_OUT[0]}}))
		else $error("lane mismatch");
	beat_min_a: assert property ($rose(READOUT_VALID) |-> READOUT_VALID[*4])
		else $error("short burst");
	beat_max_a: assert property ($rose(READOUT_VALID) |-> ##8 !READOUT_VALID)
		else $error("long burst");
	read_lat_a: assert property ($rose(READOUT_VALID) |-> since >= READ_LAT && since <= READ_LAT + 6)
		else $error("data without read");
	calib_alt_a: assert property (loc == 2'h0 && READOUT_VALID && $past(READOUT_VALID) |-> DQ_OUT[0] != $past(DQ_OUT[0]))
		else $error("pattern not alternating");
	calib_first_a: assert property (loc == 2'h0 && $rose(READOUT_VALID) |-> !DQ_OUT[0])
		else $error("first beat not zero");
	rsvd_zero_a: assert property (loc != 2'h0 && READOUT_VALID |-> DQ_OUT == 16'h0)
		else $error("reserved not zero");
	array_quiet_a: assert property (!ro_en |-> !READOUT_VALID)
		else $error("data in array mode");
	calib_c: cover property (loc == 2'h0 && $rose(READOUT_VALID));
	rsvd_c: cover property (loc != 2'h0 && $rose(READOUT_VALID));
	chop_c: cover property ($rose(READOUT_VALID) ##4 !READOUT_VALID);
endmodule // sdbs_monitor
bind sdbs_top sdbs_monitor #(.ROW_W(ROW_W), .READ_LAT(READ_LAT)) u_sdbs_monitor (.CLK_SYS(CLK_SYS), .RST(RST),
	.CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .A(A),
	.DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N), .READOUT_VALID(READOUT_VALID));

/* File: sdbs_top.v */
// Purpose: SDRAM-side bank tracking and calibration readout
// Assumes: controller keeps its own timing; one command per clock
// Notes: reads in array mode produce no data here
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`include "sdbs_defs.vh"
module sdbs_top #(
	parameter ROW_W = 16,
	parameter READ_LAT = `SDBS_READ_LAT
) (
	// Clock and reset
	input wire CLK_SYS,
	input wire RST,
	// Command and address pins
	input wire CS_N,
	input wire RAS_N,
	input wire CAS_N,
	input wire WE_N,
	input wire [2:0] BA,
	input wire [ROW_W-1:0] A,
	// Data lanes
	output reg [15:0] DQ_OUT,
	output reg DQ_OE_N,
	output reg READOUT_VALID,
	// Avalon-MM slave
	input wire [3:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	output reg [31:0] AVS_READDATA,
	output reg AVS_WAITREQUEST
);
	// Pin synchronisers, first stage read only by second
	reg [ROW_W+6:0] pin_s1;
	reg [ROW_W+6:0] pin_s2;
	always @(posedge CLK_SYS) begin
		pin_s1 <= {CS_N, RAS_N, CAS_N, WE_N, BA, A};
		pin_s2 <= pin_s1;
	end
	wire cs_n_s = pin_s2[ROW_W+6];
	wire [2:0] cmd = pin_s2[ROW_W+5:ROW_W+3];
	wire [2:0] ba = pin_s2[ROW_W+2:ROW_W];
	wire [ROW_W-1:0] addr = pin_s2[ROW_W-1:0];
	wire is_mrs = !cs_n_s && cmd == `SDBS_CMD_MRS;
	wire is_act = !cs_n_s && cmd == `SDBS_CMD_ACT;
	wire is_pre = !cs_n_s && cmd == `SDBS_CMD_PRE;
	wire is_read = !cs_n_s && cmd == `SDBS_CMD_READ;

	// Mode register copies
	reg [2:0] mode_register_three;
	reg [1:0] bl_mode;
	always @(posedge CLK_SYS) begin
		if (RST) begin
			mode_register_three <= 3'h0;
			bl_mode <= `SDBS_BL_FIXED8;
		end else if (is_mrs) begin
			// R3 R15 location and enable
			if (ba == `SDBS_BA_MODE_THREE)
				mode_register_three <= addr[2:0];
			if (ba == `SDBS_BA_MODE_ZERO)
				bl_mode <= addr[1:0];
		end
	end
	wire readout_en = mode_register_three[`SDBS_MODE_THREE_READOUT_EN];

	// Bank trackers
	wire [7:0] bank_open;
	wire [7:0] bank_busy;
	wire [ROW_W*8-1:0] bank_rows;
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_bank
			// R9 R13 one or all banks
			wire pre_hit = is_pre && (addr[`SDBS_AP_BIT] || ba == g);
			// R19 per-bank state
			sdbs_bank #(.ROW_W(ROW_W), .TRP_CYC(`SDBS_TRP_CYC)) u_bank (
				.clk(CLK_SYS),
				.rst(RST),
				.act(is_act && ba == g),
				.pre(pre_hit),
				.row(addr),
				.is_open(bank_open[g]),
				.open_row(bank_rows[ROW_W*g +: ROW_W]),
				.busy(bank_busy[g])
			);
		end
	endgenerate

	// Readout burst engine; a read during a burst is ignored
	localparam S_IDLE = 3'h1;
	localparam S_WAIT = 3'h2;
	localparam S_BURST = 3'h4;
	reg [2:0] state;
	reg [7:0] lat_cnt;
	reg [7:0] pattern;
	reg [2:0] pos;
	reg [2:0] beats_left;
	reg replicate;
	// R17 chop choice
	wire chop = bl_mode == `SDBS_BL_FIXED4 || (bl_mode == `SDBS_BL_OTF && !addr[`SDBS_BC_BIT]);
	wire cur_bit = pattern[pos];
	// Next values of the burst engine
	reg [2:0] next_state;
	reg [7:0] next_lat_cnt;
	reg [7:0] next_pattern;
	reg [2:0] next_pos;
	reg [2:0] next_beats_left;
	reg [15:0] next_dq_out;
	reg next_dq_oe_n;
	reg next_valid;
	// R16 lane 0 of each byte carries the bit
	wire [15:0] lane_image;
	genvar l;
	generate
		for (l = 0; l < 2; l = l + 1) begin : g_lane
			assign lane_image[8*l +: 8] = {{7{cur_bit & replicate}}, cur_bit};
		end
	endgenerate
	always @* begin
		next_state = state;
		next_lat_cnt = lat_cnt;
		next_pattern = pattern;
		next_pos = pos;
		next_beats_left = beats_left;
		next_dq_out = 16'h0000;
		next_dq_oe_n = 1'b1;
		next_valid = 1'b0;
		case (state)
			S_IDLE: begin
				if (is_read && readout_en) begin
					// R1 R20 location pattern
					next_pattern = (mode_register_three[1:0] == `SDBS_LOC_CALIB) ?
						`SDBS_CALIB_PATTERN : `SDBS_RSVD_PATTERN;
					// R2 R4 start position
					next_pos = (chop && addr[2]) ? 3'h4 : 3'h0;
					next_beats_left = chop ? 3'h3 : 3'h7;
					next_lat_cnt = READ_LAT[7:0];
					next_state = S_WAIT;
				end
			end
			S_WAIT: begin
				if (lat_cnt <= 8'h01)
					next_state = S_BURST;
				next_lat_cnt = lat_cnt - 8'h01;
			end
			S_BURST: begin
				// R5 R16 LSB first, lane 0
				next_dq_out = lane_image;
				next_dq_oe_n = 1'b0;
				next_valid = 1'b1;
				next_pos = pos + 3'h1;
				next_beats_left = beats_left - 3'h1;
				if (beats_left == 3'h0)
					next_state = S_IDLE;
			end
			default: next_state = S_IDLE;
		endcase
	end
	always @(posedge CLK_SYS) begin
		if (RST) begin
			state <= S_IDLE;
			lat_cnt <= 8'h00;
			pattern <= 8'h00;
			pos <= 3'h0;
			beats_left <= 3'h0;
			DQ_OUT <= 16'h0000;
			DQ_OE_N <= 1'b1;
			READOUT_VALID <= 1'b0;
		end else begin
			state <= next_state;
			lat_cnt <= next_lat_cnt;
			pattern <= next_pattern;
			pos <= next_pos;
			beats_left <= next_beats_left;
			DQ_OUT <= next_dq_out;
			DQ_OE_N <= next_dq_oe_n;
			READOUT_VALID <= next_valid;
		end
	end

	// Avalon-MM slave: one wait cycle, then answer
	reg [2:0] bank_sel;
	wire req = AVS_READ || AVS_WRITE;
	wire wr_take = AVS_WRITE && !AVS_WAITREQUEST;
	// Status word, spare bits read as zero
	wire engine_busy = state != S_IDLE;
	wire [31:0] status_word = {8'h00, bank_busy, bank_open, 2'h0, bl_mode, engine_busy, mode_register_three};
	wire [31:0] bank_row_word = {{(32-ROW_W){1'b0}}, bank_rows[ROW_W*bank_sel +: ROW_W]};
	reg [31:0] next_readdata;
	reg next_waitrequest;
	reg next_replicate;
	reg [2:0] next_bank_sel;
	always @* begin
		next_readdata = 32'h00000000;
		case (AVS_ADDRESS)
			`SDBS_ADDR_CTRL: next_readdata = {31'h00000000, replicate};
			`SDBS_ADDR_STATUS: next_readdata = status_word;
			`SDBS_ADDR_BANK_SEL: next_readdata = {29'h00000000, bank_sel};
			`SDBS_ADDR_BANK_ROW: next_readdata = bank_row_word;
			default: next_readdata = 32'h00000000;
		endcase
	end
	// Held request gets a fresh wait cycle each transfer
	always @* begin
		next_waitrequest = !(req && AVS_WAITREQUEST);
		next_replicate = replicate;
		next_bank_sel = bank_sel;
		// Writes land only at the edge that sees waitrequest low
		if (wr_take && AVS_ADDRESS == `SDBS_ADDR_CTRL)
			next_replicate = AVS_WRITEDATA[`SDBS_CTRL_REPLICATE];
		if (wr_take && AVS_ADDRESS == `SDBS_ADDR_BANK_SEL)
			next_bank_sel = AVS_WRITEDATA[2:0];
	end
	always @(posedge CLK_SYS) begin
		if (RST) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h00000000;
			replicate <= 1'b1;
			bank_sel <= 3'h0;
		end else begin
			AVS_WAITREQUEST <= next_waitrequest;
			if (AVS_READ && AVS_WAITREQUEST)
				AVS_READDATA <= next_readdata;
			replicate <= next_replicate;
			bank_sel <= next_bank_sel;
		end
	end
endmodule // sdbs_top

/* File: sdbs_top_tb.sv */
// Purpose: self-checking bench for the bank and readout block
// Assumes: 10 MHz clock, commands from the controller model
// Notes: fixed one wait cycle on the bus is not assumed
`timescale 1ns/10ps
module sdbs_top_tb;
	reg clk, rst, rd_en, wr_en;
	reg [3:0] adr;
	reg [31:0] wd, rd;
	wire [31:0] rdata;
	wire wait_req, cs_n, ras_n, cas_n, we_n, oe_n, vld;
	wire [2:0] ba;
	wire [15:0] a, dq;
	integer n_errors, samples_checked, i;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	sdbs_ctl_model u_sdbs_ctl_model (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a(a));
	sdbs_top u_sdbs_top (.CLK_SYS(clk), .RST(rst), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba),
		.A(a), .DQ_OUT(dq), .DQ_OE_N(oe_n), .READOUT_VALID(vld), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
		.AVS_WRITE(wr_en), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req));
	task chk(input string what, input [31:0] e, input [31:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("wrong value %s expected %h seen %h", what, e, g);
			end
		end
	endtask
	task avs(input w, input [3:0] ad, input [31:0] d);
		begin
			@(posedge clk);
			adr <= ad;
			wd <= d;
			rd_en <= !w;
			wr_en <= w;
			// A wait ends when waitrequest goes low; no timeout here besides the watchdog
			@(posedge clk);
			while (wait_req !== 1'b0)
				@(posedge clk);
			rd = rdata;
			rd_en <= 1'b0;
			wr_en <= 1'b0;
		end
	endtask
	task rreg(input [3:0] ad, input [31:0] e);
		begin
			avs(1'b0, ad, 32'h0);
			chk("register", e, rd);
		end
	endtask
	task cmd(input [2:0] k, input [2:0] b, input [15:0] x);
		u_sdbs_ctl_model.issue(k, b, x);
	endtask
	task burst(input [15:0] x, input integer n, input [7:0] pat, input rep);
		integer t, j;
		begin
			cmd(3'h5, 3'h0, x);
			#1;
			t = 0;
			while (vld !== 1'b1 && t < 30) begin
				@(posedge clk);
				#1;
				t = t + 1;
			end
			for (j = 0; j < n; j = j + 1) begin
				chk("beat", rep ? {16{pat[j]}} : {7'h0, pat[j], 7'h0, pat[j]}, dq);
				chk("lane enable", 0, oe_n);
				@(posedge clk);
				#1;
			end
			chk("burst end", 0, vld);
			chk("lane release", 1, oe_n);
		end
	endtask
	task close_out;
		begin
			$display("mismatches %0d checks %0d", n_errors, samples_checked);
			if (n_errors == 0 && samples_checked > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	initial begin
		n_errors = 0;
		samples_checked = 0;
		{rst, rd_en, wr_en, adr, wd} = {1'b1, 38'h0};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rreg(4'h4, 32'h0);
		rreg(4'h0, 32'h1);
		rreg(4'h2, 32'h0);
		cmd(3'h3, 3'h5, 16'h1234);
		cmd(3'h3, 3'h2, 16'hBEEF);
		avs(1'b1, 4'h8, 32'h5);
		rreg(4'hC, 32'h1234);
		rreg(4'h4, 32'h2400);
		cmd(3'h2, 3'h5, 16'h0);
		cmd(3'h2, 3'h5, 16'h0);
		rreg(4'h4, 32'h0400);
		cmd(3'h2, 3'h0, 16'h0400);
		rreg(4'h4, 32'h0);
		cmd(3'h0, 3'h3, 16'h4);
		burst(16'h1000, 8, 8'hAA, 1'b1);
		cmd(3'h0, 3'h0, 16'h1);
		burst(16'h0, 4, 8'hAA, 1'b1);
		burst(16'h4, 4, 8'h0A, 1'b1);
		avs(1'b1, 4'h0, 32'h0);
		burst(16'h1000, 8, 8'hAA, 1'b0);
		cmd(3'h3, 3'h3, 16'h7);
		for (i = 1; i < 4; i = i + 1) begin
			cmd(3'h0, 3'h3, 16'h4 | i);
			burst(16'h1000, 8, 8'h0, 1'b0);
		end
		rreg(4'h4, 32'h0817);
		cmd(3'h0, 3'h3, 16'h0);
		burst(16'h1000, 0, 8'h0, 1'b0);
		close_out;
	end
	initial begin
		repeat (3000) @(posedge clk);
		n_errors = n_errors + 1;
		close_out;
	end
endmodule // sdbs_top_tb
